// [include/soft_ramp_pkg.sv]
// Constants shared by the half-bridge soft ramp sequencer.
// Assumes one 100 MHz device clock and pins that are synchronised inside.
`default_nettype none
package soft_ramp_pkg;
  // ---------------------------------------------------------------
  // Ramp level encoding.
  // ---------------------------------------------------------------
  // Width of the ramp level handed to the output stage.
  localparam int LEVEL_W = 8;
  // Level that stands for power ground.
  localparam logic [7:0] LEVEL_GROUND = 8'h00;
  // Level that stands for the mid-supply bias point.
  localparam logic [7:0] LEVEL_BIAS = 8'h80;
  // ---------------------------------------------------------------
  // Timing.
  // ---------------------------------------------------------------
  // Clock period in nanoseconds.
  localparam int CLK_PERIOD_NS = 10;
  // Default clock cycles per ramp step.
  localparam int STEP_CYCLES = 16;
  // Clock cycles after which a PWM input with no edge counts as idle.
  localparam int PWM_IDLE_CYCLES = 256;
  // Number of synchroniser stages on pin inputs.
  localparam int SYNC_STAGES = 2;
endpackage
`default_nettype wire

// [rtl/pin_sync.sv]
// Two-flop synchroniser for a vector of asynchronous pin levels.
// Assumes the inputs are quasi-static levels, not multi-bit words.
`timescale 1ns/1ns
`default_nettype none
module pin_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic clk_en,
  input wire logic reset,
  input wire logic [WIDTH-1:0] async_in,
  output var logic [WIDTH-1:0] sync_out
);
  // ---------------------------------------------------------------
  // Synchroniser stages.
  // ---------------------------------------------------------------
  // First stage; read only by the second stage.
  logic [WIDTH-1:0] meta;
  // Both stages clear on reset so downstream sees a defined low.
  always_ff @(posedge clk) begin
    if (reset) begin
      meta <= '0;
      sync_out <= '0;
    end else if (clk_en) begin
      meta <= async_in;
      sync_out <= meta;
    end
  end
endmodule
`default_nettype wire

// [rtl/halfbridge_soft_ramp_sequencer.sv]
// Soft start and soft stop sequencer for one channel pair of half-bridges.
// Assumes pins arrive asynchronously and the output stage reads the level,
// drive enable and switching enable from this block.
`timescale 1ns/1ns
`default_nettype none
module halfbridge_soft_ramp_sequencer #(
  parameter int CHANNELS = 2,
  parameter int STEP_CYCLES = soft_ramp_pkg::STEP_CYCLES,
  parameter int IDLE_CYCLES = soft_ramp_pkg::PWM_IDLE_CYCLES
) (
  input wire logic clk,
  input wire logic clk_en,
  input wire logic reset,
  input wire logic pair_reset_n,
  input wire logic ramp_select,
  input wire logic [CHANNELS-1:0] pwm_input,
  output logic [CHANNELS-1:0] power_output,
  output logic [CHANNELS-1:0] power_output_oe,
  output logic [soft_ramp_pkg::LEVEL_W-1:0] ramp_level,
  output logic ramp_active,
  output logic low_power
);
  // ---------------------------------------------------------------
  // Elaboration checks.
  // ---------------------------------------------------------------
  if (CHANNELS < 1 || STEP_CYCLES < 1 || IDLE_CYCLES < 2) begin : g_bad
    $error("Channel count and cycle counts must be positive.");
  end

  localparam int LW = soft_ramp_pkg::LEVEL_W;
  localparam int SW = $clog2(STEP_CYCLES + 1);
  localparam int IW = $clog2(IDLE_CYCLES + 1);
  localparam logic [SW-1:0] STEP_LAST = SW'(STEP_CYCLES - 1);
  localparam logic [IW-1:0] IDLE_LAST = IW'(IDLE_CYCLES - 1);

  // Sequencer states.
  typedef enum logic [2:0] {
    st_off, st_wait_pwm, st_ramp_up, st_run, st_ramp_down
  } seq_state_t;

  // ---------------------------------------------------------------
  // Pin synchronisation.
  // ---------------------------------------------------------------
  // Synchronised copies of the control pins and PWM inputs.
  logic [CHANNELS+1:0] pins_sync;
  pin_sync #(.WIDTH(CHANNELS + 2)) u_sync (
    .clk(clk),
    .clk_en(clk_en),
    .reset(reset),
    .async_in({ramp_select, pair_reset_n, pwm_input}),
    .sync_out(pins_sync)
  );
  // Synchronised pair reset release, active high when released.
  logic released;
  // Synchronised ramp selection pin.
  logic ramp_pin;
  // Synchronised PWM levels.
  logic [CHANNELS-1:0] pwm_s;
  assign released = pins_sync[CHANNELS];
  assign ramp_pin = pins_sync[CHANNELS+1];
  assign pwm_s = pins_sync[CHANNELS-1:0];

  // State register.
  seq_state_t state;
  // Ramp mode latched at release.
  logic ramp_mode;
  // Cycle counter within one ramp step.
  logic [SW-1:0] step_cnt;
  // Previous PWM levels for edge detection.
  logic [CHANNELS-1:0] pwm_prev;
  // Per-channel toggle activity flags.
  logic [CHANNELS-1:0] pwm_alive;
  // Combined flag: every channel is toggling.
  logic all_alive;
  // Step strobe, one cycle every STEP_CYCLES cycles during a ramp.
  logic step_tick;

  assign all_alive = &pwm_alive;
  assign step_tick = (step_cnt == STEP_LAST);

  // ---------------------------------------------------------------
  // PWM activity detection, one watchdog per channel.
  // ---------------------------------------------------------------
  // Edge detection reads only the second synchroniser stage. A channel
  // counts as toggling until IDLE_CYCLES pass without an edge.
  always_ff @(posedge clk) begin
    if (reset) begin
      pwm_prev <= '0;
    end else if (clk_en) begin
      pwm_prev <= pwm_s;
    end
  end

  for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_alive
    // Cycles since the last edge on this channel.
    logic [IW-1:0] idle_cnt;
    always_ff @(posedge clk) begin
      if (reset || !released) begin
        idle_cnt <= '0;
        pwm_alive[ch] <= 1'b0;
      end else if (clk_en) begin
        if (pwm_s[ch] != pwm_prev[ch]) begin
          // Edge seen: channel is alive.
          idle_cnt <= '0;
          pwm_alive[ch] <= 1'b1;
        end else if (idle_cnt == IDLE_LAST) begin
          // Too long without an edge: treat as stopped.
          pwm_alive[ch] <= 1'b0;
        end else begin
          idle_cnt <= idle_cnt + IW'(1);
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Mode load.
  // ---------------------------------------------------------------
  // The ramp mode is captured only while leaving the off state, so a
  // change on the pin mid-operation does not disturb a running ramp.
  always_ff @(posedge clk) begin
    if (reset) begin
      ramp_mode <= 1'b0;
    end else if (clk_en && state == st_off && released) begin
      ramp_mode <= ramp_pin;
    end
  end

  // ---------------------------------------------------------------
  // Step timer; length of the ramp is steps times STEP_CYCLES.
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      step_cnt <= '0;
    end else if (clk_en) begin
      if (state != st_ramp_up && state != st_ramp_down) begin
        step_cnt <= '0;
      end else if (step_tick) begin
        step_cnt <= '0;
      end else begin
        step_cnt <= step_cnt + SW'(1);
      end
    end
  end

  // ---------------------------------------------------------------
  // Sequencer state machine.
  // ---------------------------------------------------------------
  // A reversal mid-ramp keeps the present level and turns direction,
  // so the capacitor sees no jump when a ramp turns.
  always_ff @(posedge clk) begin
    if (reset) begin
      state <= st_off;
    end else if (clk_en) begin
      unique case (state)
        st_off: begin
          if (released) begin
            if (ramp_pin) begin
              state <= st_wait_pwm;
            end else begin
              state <= st_run;
            end
          end
        end
        st_wait_pwm: begin
          if (!released) begin
            state <= st_off;
          end else if (all_alive) begin
            state <= st_ramp_up;
          end
        end
        st_ramp_up: begin
          if (!released) begin
            state <= st_ramp_down;
          end else if (step_tick && ramp_level == soft_ramp_pkg::LEVEL_BIAS)
          begin
            state <= st_run;
          end
        end
        st_run: begin
          if (!released) begin
            if (ramp_mode) begin
              state <= st_ramp_down;
            end else begin
              state <= st_off;
            end
          end
        end
        st_ramp_down: begin
          if (released) begin
            state <= st_ramp_up;
          end else if (step_tick &&
                       ramp_level == soft_ramp_pkg::LEVEL_GROUND) begin
            state <= st_off;
          end
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Ramp level.
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      ramp_level <= soft_ramp_pkg::LEVEL_GROUND;
    end else if (clk_en) begin
      if (state == st_ramp_up && step_tick &&
          ramp_level != soft_ramp_pkg::LEVEL_BIAS) begin
        ramp_level <= ramp_level + LW'(1);
      end else if (state == st_ramp_down && step_tick &&
                   ramp_level != soft_ramp_pkg::LEVEL_GROUND) begin
        ramp_level <= ramp_level - LW'(1);
      end else if (state == st_run) begin
        ramp_level <= soft_ramp_pkg::LEVEL_BIAS;
      end else if (state == st_off) begin
        ramp_level <= soft_ramp_pkg::LEVEL_GROUND;
      end
    end
  end

  // ---------------------------------------------------------------
  // Output stage controls.
  // ---------------------------------------------------------------
  // Outputs switch only in run; during ramps the stage holds its level
  // and drives, otherwise it floats.
  always_ff @(posedge clk) begin
    if (reset) begin
      power_output <= '0;
      power_output_oe <= '0;
      ramp_active <= 1'b0;
      low_power <= 1'b1;
    end else if (clk_en) begin
      ramp_active <= (state == st_ramp_up || state == st_ramp_down);
      low_power <= (state == st_off);
      if (state == st_run) begin
        power_output <= pwm_s;
        power_output_oe <= '1;
      end else if (state == st_ramp_up || state == st_ramp_down) begin
        power_output <= '0;
        power_output_oe <= '1;
      end else begin
        power_output <= '0;
        power_output_oe <= '0;
      end
    end
  end
endmodule
`default_nettype wire

// [verification/soft_ramp_checker_sva.sv]
// Assertions on the ports of the soft ramp sequencer.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/1ns
`default_nettype none
module soft_ramp_checker #(
  parameter int CHANNELS = 2
) (
  input wire logic clk,
  input wire logic clk_en,
  input wire logic reset,
  input wire logic pair_reset_n,
  input wire logic ramp_select,
  input wire logic [CHANNELS-1:0] pwm_input,
  input wire logic [CHANNELS-1:0] power_output,
  input wire logic [CHANNELS-1:0] power_output_oe,
  input wire logic [soft_ramp_pkg::LEVEL_W-1:0] ramp_level,
  input wire logic ramp_active,
  input wire logic low_power
);
  // ------------------------------------------------------------
  // Properties, all on the one clock and its reset.
  // ------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // Ramp choice seen when the pair leaves reset from the off state; the
  // pin may change later without changing how the pair shuts down.
  logic latched_ramp;
  always_ff @(posedge clk) begin
    if (reset) begin
      latched_ramp <= 1'b0;
    end else if ($rose(pair_reset_n) && low_power) begin
      latched_ramp <= ramp_select;
    end
  end
  property p_off_hiz;
    low_power |-> power_output_oe == '0;
  endproperty
  a_off_hiz: assert property (p_off_hiz) else $error("drive in off");
  property p_off_level;
    low_power |-> ramp_level == soft_ramp_pkg::LEVEL_GROUND;
  endproperty
  a_off_level: assert property (p_off_level) else $error("off level");
  property p_ramp_quiet;
    ramp_active |-> power_output == '0;
  endproperty
  a_ramp_quiet: assert property (p_ramp_quiet) else $error("ramp pwm");
  property p_step;
    ramp_active && $past(ramp_active) |-> ramp_level == $past(ramp_level)
      || ramp_level == $past(ramp_level) + 8'h01
      || ramp_level == $past(ramp_level) - 8'h01;
  endproperty
  a_step: assert property (p_step) else $error("ramp jump");
  property p_noramp_on;
    $rose(pair_reset_n) && !ramp_select && low_power
      |-> ##[1:6] power_output_oe == '1;
  endproperty
  a_noramp_on: assert property (p_noramp_on) else $error("late start");
  property p_noramp_off;
    $fell(pair_reset_n) && !latched_ramp && power_output_oe == '1
      && !ramp_active |-> ##[1:6] power_output_oe == '0;
  endproperty
  a_noramp_off: assert property (p_noramp_off) else $error("late hiz");
  property p_down_end;
    $fell(ramp_active) && $past(ramp_level) == soft_ramp_pkg::LEVEL_GROUND
      |-> ##[0:2] (low_power && power_output_oe == '0);
  endproperty
  a_down_end: assert property (p_down_end) else $error("no hiz");
  property p_up_end;
    $fell(ramp_active) && $past(ramp_level) == soft_ramp_pkg::LEVEL_BIAS
      |-> ##[0:2] power_output_oe == '1;
  endproperty
  a_up_end: assert property (p_up_end) else $error("no run");
  // In normal switching each output copies its PWM pin three edges late.
  property p_run_follow;
    clk_en && $past(clk_en) && power_output_oe == '1 && !ramp_active
      |-> power_output == $past(pwm_input, 3);
  endproperty
  a_run_follow: assert property (p_run_follow) else $error("pwm lost");
endmodule
`default_nettype wire

// [verification/pwm_modulator_model.sv]
// Model of the external PWM modulator feeding the pwm inputs.
// Assumes the bench starts it before releasing the pair reset.
`timescale 1ns/1ns
`default_nettype none
module pwm_modulator_model #(
  parameter int CHANNELS = 2
) (
  input wire logic clk,
  input wire logic run,
  output var logic [CHANNELS-1:0] pwm_input
);
  // Phase count; even channels take tap 1 and odd channels tap 2, so neighbouring edges differ.
  logic [3:0] phase = 4'h0;
  // A stopped modulator holds its last level, as a real one would.
  always @(posedge clk) begin
    if (run) begin
      phase <= phase + 4'h1;
    end
  end
  // Each pin is one tap of the phase count, so it has a single driver.
  always_comb begin
    for (int c = 0; c < CHANNELS; c++) begin
      pwm_input[c] = phase[c % 2 + 1];
    end
  end
endmodule
`default_nettype wire

// [verification/test_halfbridge_soft_ramp_sequencer.sv]
// Self-checking bench for the soft ramp sequencer.
// Assumes the package, checker and modulator model are compiled first.
`timescale 1ns/1ns
`default_nettype none
module test_halfbridge_soft_ramp_sequencer;
  localparam int CH = 2;
  localparam logic [7:0] BIAS = soft_ramp_pkg::LEVEL_BIAS;
  // Cycles per ramp step in the design under test.
  localparam int STEP = 2;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic clk_en = 1'b1;
  // The pair stays in reset until the bench has settled its clock.
  logic pair_reset_n = 1'b0;
  // Only half-bridge outputs are modelled, so ramping may be chosen.
  logic ramp_select = 1'b0;
  logic pwm_run = 1'b0;
  logic [CH-1:0] pwm_input;
  logic [CH-1:0] power_output;
  logic [CH-1:0] power_output_oe;
  logic [7:0] ramp_level;
  logic [7:0] lvl;
  int spent;
  logic ramp_active;
  logic low_power;
  int miscompares = 0;
  int n_checks = 0;
  always #5 clk = ~clk;
  pwm_modulator_model #(.CHANNELS(CH)) u_pwm (.clk(clk), .run(pwm_run),
    .pwm_input(pwm_input));
  // Short steps and idle span keep the ramps to a few hundred cycles.
  halfbridge_soft_ramp_sequencer #(.CHANNELS(CH), .STEP_CYCLES(STEP),
    .IDLE_CYCLES(8)) DUT (.clk(clk), .clk_en(clk_en), .reset(reset),
    .pair_reset_n(pair_reset_n), .ramp_select(ramp_select),
    .pwm_input(pwm_input), .power_output(power_output),
    .power_output_oe(power_output_oe), .ramp_level(ramp_level),
    .ramp_active(ramp_active), .low_power(low_power));
  // ------------------------------------------------------------
  // Shared helpers.
  // ------------------------------------------------------------
  task automatic check(input string what, input logic [7:0] seen,
      input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Waits n edges, then 1 ns so that outputs have settled.
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic pins(input logic rst_n, input logic sel);
    @(posedge clk);
    pair_reset_n <= rst_n;
    ramp_select <= sel;
    #1;
  endtask
  // Returns in n the number of edges waited.
  task automatic wait_ramp(input logic val, input int lim, output int n);
    for (n = 0; n < lim && ramp_active !== val; n++) cyc(1);
  endtask
  task automatic end_of_test();
    if (miscompares == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // ------------------------------------------------------------
  // Scenarios.
  // ------------------------------------------------------------
  task automatic t_no_ramp();
    check("oe idle", 8'(power_output_oe), 8'h00);
    check("lp idle", 8'(low_power), 8'h01);
    @(posedge clk) pwm_run <= 1'b1;
    pins(1'b1, 1'b0);
    cyc(6);
    check("oe run", 8'(power_output_oe), 8'h03);
    pins(1'b0, 1'b0);
    cyc(6);
    check("oe stop", 8'(power_output_oe), 8'h00);
    check("lp stop", 8'(low_power), 8'h01);
  endtask
  // A silent modulator must hold the up-ramp back.
  task automatic t_stalled();
    @(posedge clk) pwm_run <= 1'b0;
    pins(1'b1, 1'b1);
    cyc(40);
    check("stall", 8'(ramp_active), 8'h00);
    pins(1'b0, 1'b1);
    cyc(6);
  endtask
  task automatic t_ramp_up();
    @(posedge clk) pwm_run <= 1'b1;
    cyc(4);
    pins(1'b1, 1'b1);
    wait_ramp(1'b1, 60, spent);
    check("up act", 8'(ramp_active), 8'h01);
    pins(1'b1, 1'b0);
    cyc(20);
    check("up quiet", 8'(power_output), 8'h00);
    check("mode kept", 8'(ramp_active), 8'h01);
    // The pin stays low from here on; the latched mode must still rule.
    pins(1'b1, 1'b0);
    wait_ramp(1'b0, 400, spent);
    // 129 steps of STEP cycles, less the 22 cycles spent above.
    check("ramp len", 8'(spent), 8'((int'(BIAS) + 1) * STEP - 22));
    check("bias", ramp_level, BIAS);
    check("oe bias", 8'(power_output_oe), 8'h03);
  endtask
  // Turn the ramp round twice before letting it finish downwards.
  task automatic t_reverse();
    pins(1'b0, 1'b0);
    wait_ramp(1'b1, 10, spent);
    check("mode down", 8'(ramp_active), 8'h01);
    cyc(60);
    check("down", 8'(ramp_level < BIAS), 8'h01);
    // With the enable low, the level must hold however long it waits.
    @(posedge clk) clk_en <= 1'b0;
    #1 lvl = ramp_level;
    cyc(10);
    check("freeze", ramp_level, lvl);
    @(posedge clk) clk_en <= 1'b1;
    cyc(1);
    lvl = ramp_level;
    pins(1'b1, 1'b0);
    cyc(20);
    check("turn up", 8'(ramp_level > lvl), 8'h01);
    pins(1'b0, 1'b0);
    wait_ramp(1'b0, 400, spent);
    cyc(2);
    check("lp end", 8'(low_power), 8'h01);
    check("oe end", 8'(power_output_oe), 8'h00);
  endtask
  initial begin
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    cyc(2);
    t_no_ramp();
    t_stalled();
    t_ramp_up();
    t_reverse();
    end_of_test();
  end
  // Watchdog: the whole sequence needs well under 3000 cycles.
  initial begin
    cyc(3000);
    miscompares++;
    end_of_test();
  end
endmodule
bind halfbridge_soft_ramp_sequencer soft_ramp_checker #(.CHANNELS(CHANNELS))
  u_chk (.clk(clk), .clk_en(clk_en), .reset(reset),
  .pair_reset_n(pair_reset_n), .ramp_select(ramp_select),
  .pwm_input(pwm_input), .power_output(power_output),
  .power_output_oe(power_output_oe), .ramp_level(ramp_level),
  .ramp_active(ramp_active), .low_power(low_power));
`default_nettype wire
